/* File: rtl/asc_clk_ratio.sv */
// Conversion clock edge counter derived from the peripheral bus clock.
`timescale 1ns/1ps
`default_nettype none
module asc_clk_ratio (
  input wire logic pclk, // Peripheral bus clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic [2:0] ratio, // Selected frequency ratio code.
  output logic [1:0] step_q // Conversion clock edges in this bus cycle.
);
  logic [2:0] div_q;
  logic [2:0] div_max;
  logic wrap;

  // Divider length for the slower conversion clock settings.
  assign div_max = (ratio == asc_pkg::RATIO_2_1) ? 3'h1 :
                   (ratio == asc_pkg::RATIO_4_1) ? 3'h3 :
                   (ratio == asc_pkg::RATIO_8_1) ? 3'h7 : 3'h0;
  assign wrap = (div_q >= div_max);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_q <= 3'h0;
      step_q <= 2'h0;
    end
    else
    begin
      div_q <= wrap ? 3'h0 : div_q + 3'h1;
      step_q <= (ratio == asc_pkg::RATIO_1_2) ? 2'h2 : {1'b0, wrap};
    end
  end
endmodule // asc_clk_ratio
`default_nettype wire

/* File: rtl/asc_ctrl.sv */
// Top of the A/D result storage controller with its APB register slave.
`timescale 1ns/1ps
`default_nettype none
`include "asc_defs.svh"
module asc_ctrl #(
  parameter int NCH = 18 // Analog input channels.
) (
  input wire logic pclk, // Peripheral bus clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction.
  input wire logic [7:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata_q, // APB read data.
  output logic pready_q, // APB ready.
  output logic pslverr_q, // APB error on unmapped address.
  input wire logic trig_a, // Group A or scan start trigger pulse.
  input wire logic trig_b, // Group B trigger pulse.
  input wire logic [11:0] analog_code, // Converter code at end of conversion.
  output logic sh_start_q, // Pulse starting one conversion.
  output logic [4:0] sh_chan_q, // Source being converted.
  output logic busy_q // Scan in progress.
);
  asc_pkg::asc_ctrl_s ctrl_q;
  asc_pkg::asc_state_e state_q;
  asc_pkg::asc_wr_s wr;
  logic [NCH-1:0] sel_a_q, sel_b_q;
  logic [4:0] idx_q, rep_q;
  logic [5:0] cnt_q;
  logic [15:0] acc_q;
  logic grp_b_q, second_q;
  logic [1:0] step;
  logic [15:0] mem_rdata;

  // APB decode.
  wire acc_ph = psel && penable && !pready_q;
  wire wr_go = acc_ph && pwrite;
  wire hit_ctrl = (paddr == `ASC_OFF_CTRL);
  wire hit_cmd = (paddr == `ASC_OFF_CMD);
  wire hit_stat = (paddr == `ASC_OFF_STAT);
  wire hit_sela = (paddr == `ASC_OFF_SELA);
  wire hit_selb = (paddr == `ASC_OFF_SELB);
  wire hit_res = (paddr >= `ASC_OFF_RES) && (paddr <= `ASC_OFF_RES_END) && (paddr[1:0] == 2'h0);
  wire hit_any = hit_ctrl || hit_cmd || hit_stat || hit_sela || hit_selb || hit_res;
  wire [5:0] res_word = paddr[7:2] - 6'(`ASC_OFF_RES >> 2);
  wire cmd_wr = wr_go && hit_cmd;

  // Mode decode.
  wire is_cont = (ctrl_q.mode == asc_pkg::SCAN_CONT);
  wire is_group = (ctrl_q.mode == asc_pkg::SCAN_GROUP);
  wire dbl_ok = ctrl_q.dbl && !is_cont;
  wire start_a = trig_a || (cmd_wr && pwdata[`ASC_CMD_START]);
  wire start_b = is_group && (trig_b || (cmd_wr && pwdata[`ASC_CMD_TRIGB]));
  wire stop = cmd_wr && pwdata[`ASC_CMD_STOP];
  wire abort_b = is_group && ctrl_q.gapri && grp_b_q && (state_q != asc_pkg::ST_IDLE) && start_a;

  // Sources selected for this scan; extras convert with group A, single scan or continuous scan.
  wire [`ASC_IDX_LAST:0] all_mask = grp_b_q ?
    {3'h0, sel_b_q} : {ctrl_q.diag_en, ctrl_q.vref_en, ctrl_q.temp_en, sel_a_q};
  wire [`ASC_IDX_LAST:0] dbl_mask = (`ASC_IDX_LAST + 1)'(1) << ctrl_q.dbl_ch;
  wire [`ASC_IDX_LAST:0] mask = dbl_ok ? dbl_mask : all_mask;
  wire scan_end = (idx_q > `ASC_IDX_LAST);
  wire take = !scan_end && mask[idx_q[4:0]];

  wire [5:0] target = ctrl_q.cyc_fast ? 6'(`ASC_CYC_FAST) : 6'(`ASC_CYC_SLOW);
  wire [6:0] cnt_next = {1'b0, cnt_q} + {5'h0, step};
  wire conv_done = (state_q == asc_pkg::ST_CONV) && (cnt_next >= {1'b0, target});

  wire [4:0] add_last = ctrl_q.add16 ? `ASC_ADD_LONG : `ASC_ADD_SHORT;
  wire add_more = ctrl_q.add_en && (rep_q != add_last);
  wire [15:0] sum = acc_q + {4'h0, analog_code};

  wire [4:0] home = (idx_q >= `ASC_IDX_TEMP) ? idx_q + 5'h1 : idx_q;
  assign wr.we = conv_done && !add_more && !abort_b;
  assign wr.addr = (dbl_ok && second_q) ? `ASC_MEM_DUP : home;
  assign wr.data = ctrl_q.add_en ? sum : {4'h0, analog_code};

  asc_clk_ratio u_ratio (
    .pclk(pclk),
    .presetn(presetn),
    .ratio(ctrl_q.ratio),
    .step_q(step)
  );

  asc_result_mem #(.DEPTH(`ASC_IDX_LAST + 2)) u_mem (
    .pclk(pclk),
    .presetn(presetn),
    .wr(wr),
    .raddr(res_word[4:0]),
    .rdata_q(mem_rdata)
  );

  // Register writes; result words take no bus writes.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= '0;
      sel_a_q <= '0;
      sel_b_q <= '0;
    end
    else if (wr_go)
    begin
      if (hit_ctrl)
        ctrl_q <= {14'h0000, pwdata[17:0]};
      else if (hit_sela)
        sel_a_q <= pwdata[NCH-1:0];
      else if (hit_selb)
        sel_b_q <= pwdata[NCH-1:0];
    end
  end

  // Read mux, one wait state so the result store can answer.
  wire [31:0] stat_w = {24'h0, second_q, grp_b_q, idx_q, busy_q};
  wire [31:0] rd_mux = hit_ctrl ? ctrl_q :
                       hit_stat ? stat_w :
                       hit_sela ? 32'(sel_a_q) :
                       hit_selb ? 32'(sel_b_q) :
                       hit_res ? {16'h0000, mem_rdata} : 32'h0;

  // APB answer.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end
    else
    begin
      pready_q <= acc_ph;
      pslverr_q <= acc_ph && !hit_any;
      prdata_q <= (acc_ph && !pwrite) ? rd_mux : 32'h0;
    end
  end

  // Scan sequencer.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= asc_pkg::ST_IDLE;
      idx_q <= 5'h0;
      cnt_q <= 6'h0;
      rep_q <= 5'h0;
      acc_q <= 16'h0;
      grp_b_q <= 1'b0;
      second_q <= 1'b0;
      sh_start_q <= 1'b0;
      sh_chan_q <= 5'h0;
      busy_q <= 1'b0;
    end
    else
    begin
      sh_start_q <= 1'b0;
      if (stop)
      begin
        state_q <= asc_pkg::ST_IDLE;
        busy_q <= 1'b0;
      end
      else if (abort_b)
      begin
        grp_b_q <= 1'b0;
        idx_q <= 5'h0;
        acc_q <= 16'h0;
        rep_q <= 5'h0;
        state_q <= asc_pkg::ST_SEEK;
      end
      else
      begin
        case (state_q)
          asc_pkg::ST_IDLE:
          begin
            if (start_a || start_b)
            begin
              grp_b_q <= !start_a;
              idx_q <= 5'h0;
              state_q <= asc_pkg::ST_SEEK;
              busy_q <= 1'b1;
            end
          end
          asc_pkg::ST_SEEK:
          begin
            if (scan_end)
            begin
              if (is_cont)
                idx_q <= 5'h0;
              else
              begin
                state_q <= asc_pkg::ST_IDLE;
                busy_q <= 1'b0;
                second_q <= dbl_ok && !second_q;
              end
            end
            else if (take)
            begin
              state_q <= asc_pkg::ST_CONV;
              cnt_q <= 6'h0;
              rep_q <= 5'h0;
              acc_q <= 16'h0;
              sh_start_q <= 1'b1;
              sh_chan_q <= idx_q;
            end
            else
              idx_q <= idx_q + 5'h1;
          end
          asc_pkg::ST_CONV:
          begin
            cnt_q <= cnt_next[5:0];
            if (conv_done)
            begin
              cnt_q <= 6'h0;
              if (add_more)
              begin
                acc_q <= sum;
                rep_q <= rep_q + 5'h1;
                sh_start_q <= 1'b1;
              end
              else
              begin
                idx_q <= idx_q + 5'h1;
                state_q <= asc_pkg::ST_SEEK;
              end
            end
          end
          default:
            state_q <= asc_pkg::ST_IDLE;
        endcase
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Bus clock cycles from a conversion start to its last count at the 1:1 ratio.
  localparam int CONV_SLOW_LAST = `ASC_CYC_SLOW - 1;
  localparam int CONV_FAST_LAST = `ASC_CYC_FAST - 1;

  sequence s_b_busy;
    grp_b_q && busy_q && is_group && ctrl_q.gapri;
  endsequence
  sequence s_a_trig;
    trig_a && !stop;
  endsequence

  chk_code_width: assert property (wr.we && !ctrl_q.add_en |-> wr.data[15:12] == 4'h0)
    else $error("plain result wider than 12 bits");
  chk_ratio_step: assert property (ctrl_q.ratio == asc_pkg::RATIO_8_1 && step != 2'h0
    |=> (step == 2'h0 || ctrl_q.ratio != asc_pkg::RATIO_8_1) [*7])
    else $error("8:1 ratio gave early conversion clock edge");
  chk_conv_time: assert property (conv_done |-> cnt_q < target && cnt_next >= {1'b0, target})
    else $error("conversion ended at wrong count");

  // Conversion length measured in bus cycles, apart from the step counter compare.
  chk_slow_len: assert property (@(posedge pclk) disable iff (!presetn || stop || abort_b)
    sh_start_q && ctrl_q.ratio == asc_pkg::RATIO_1_1 && !ctrl_q.cyc_fast
    |-> ##CONV_SLOW_LAST conv_done)
    else $error("slow conversion took the wrong time");
  chk_fast_len: assert property (@(posedge pclk) disable iff (!presetn || stop || abort_b)
    sh_start_q && ctrl_q.ratio == asc_pkg::RATIO_1_1 && ctrl_q.cyc_fast
    |-> ##CONV_FAST_LAST conv_done)
    else $error("fast conversion took the wrong time");

  chk_dup_use: assert property (wr.we && wr.addr == `ASC_MEM_DUP |-> dbl_ok && second_q)
    else $error("duplication register written outside double trigger");
  chk_extra_home: assert property (wr.we && idx_q >= `ASC_IDX_TEMP && !second_q
    |-> wr.addr == idx_q + 5'h1)
    else $error("extra source result misplaced");
  chk_add_count: assert property (wr.we && ctrl_q.add_en |-> rep_q == add_last)
    else $error("sum stored before all additions");
  chk_add_width: assert property (wr.we && ctrl_q.add_en && !ctrl_q.add16
    |-> wr.data[15:14] == 2'h0)
    else $error("four-sample sum wider than two extra bits");
  chk_dbl_cont: assert property (is_cont && wr.we |-> wr.addr != `ASC_MEM_DUP)
    else $error("double trigger active in continuous scan");
  chk_scan_once: assert property (state_q == asc_pkg::ST_SEEK && scan_end && !is_cont
    && !stop && !abort_b |=> state_q == asc_pkg::ST_IDLE && !busy_q)
    else $error("single scan did not finish");
  chk_scan_repeat: assert property (state_q == asc_pkg::ST_SEEK && scan_end && is_cont
    && !stop |=> busy_q && idx_q == 5'h0)
    else $error("continuous scan did not repeat");
  chk_a_priority: assert property (s_b_busy ##0 s_a_trig
    |=> !grp_b_q && state_q == asc_pkg::ST_SEEK ##1 idx_q <= 5'h1)
    else $error("group A trigger did not preempt group B");
  chk_write_src: assert property (wr.we |-> state_q == asc_pkg::ST_CONV && conv_done)
    else $error("result written without a finished conversion");

  // First double trigger result must land in the selected channel's own word.
  chk_dbl_first: assert property (wr.we && dbl_ok && !second_q && ctrl_q.dbl_ch < 5'(NCH)
    |-> wr.addr == ctrl_q.dbl_ch)
    else $error("first double trigger result missed its channel register");
  chk_extra_grp: assert property (sh_start_q && grp_b_q |-> sh_chan_q < `ASC_IDX_TEMP)
    else $error("extra source converted during group B");
endmodule // asc_ctrl
`default_nettype wire

/* File: rtl/asc_defs.svh */
// Constants for the A/D result storage controller.
// Overview of operation
// - Each result is 12 bits and lands in its source's data register.
// - Conversion clock runs at 1:1, 1:2, 2:1, 4:1 or 8:1 to bus clock.
// - Cycle bit picks conversion time: 0.88 us clear, 0.67 us set, at 48 MHz.
// - Eighteen channel result registers plus one duplication register for double trigger.
// - Temperature, internal reference and self-diagnosis have their own result registers.
// - Addition mode sums results, storing 2 or 4 extra bits.
// - Double trigger mode only works in single scan or group scan.
// - Double trigger: first result to channel register, second to duplication register.
// - Continuous scan repeats until stopped; single scan converts once.
// - With group A priority, a group A trigger aborts group B and starts A.
`ifndef ASC_DEFS_SVH
`define ASC_DEFS_SVH
`define ASC_OFF_CTRL 8'h00
`define ASC_OFF_CMD 8'h04
`define ASC_OFF_STAT 8'h08
`define ASC_OFF_SELA 8'h0c
`define ASC_OFF_SELB 8'h10
`define ASC_OFF_RES 8'h40
`define ASC_OFF_RES_END 8'h94
`define ASC_CMD_START 0
`define ASC_CMD_TRIGB 1
`define ASC_CMD_STOP 2
`define ASC_IDX_TEMP 5'h12
`define ASC_IDX_LAST 5'h14
`define ASC_MEM_DUP 5'h12
`define ASC_CONV_MHZ 48
`define ASC_TIME_SLOW_NS 880
`define ASC_TIME_FAST_NS 670
`define ASC_CYC_SLOW ((`ASC_TIME_SLOW_NS * `ASC_CONV_MHZ) / 1000)
`define ASC_CYC_FAST ((`ASC_TIME_FAST_NS * `ASC_CONV_MHZ) / 1000)
`define ASC_ADD_SHORT 5'h03
`define ASC_ADD_LONG 5'h0f
`endif

/* File: rtl/asc_pkg.sv */
// Types shared by the A/D result storage controller.
`default_nettype none
package asc_pkg;
  typedef enum logic [1:0] {SCAN_SINGLE, SCAN_CONT, SCAN_GROUP, SCAN_RSVD} asc_mode_e;
  typedef enum logic [1:0] {ST_IDLE, ST_SEEK, ST_CONV} asc_state_e;
  typedef enum logic [2:0] {RATIO_1_1, RATIO_1_2, RATIO_2_1, RATIO_4_1, RATIO_8_1} asc_ratio_e;
  // Control register layout, most significant field first.
  typedef struct packed {
    logic [13:0] rsvd;
    logic diag_en;
    logic vref_en;
    logic temp_en;
    logic [4:0] dbl_ch;
    logic [2:0] ratio;
    logic gapri;
    logic add16;
    logic add_en;
    logic dbl;
    logic cyc_fast;
    logic [1:0] mode;
  } asc_ctrl_s;
  // One write into the result store.
  typedef struct packed {
    logic we;
    logic [4:0] addr;
    logic [15:0] data;
  } asc_wr_s;
endpackage
`default_nettype wire

/* File: rtl/asc_result_mem.sv */
// Result store: channel, duplication and extra source registers.
`timescale 1ns/1ps
`default_nettype none
module asc_result_mem #(
  parameter int DEPTH = 22 // Number of result words.
) (
  input wire logic pclk, // Clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire asc_pkg::asc_wr_s wr, // Write from conversion logic only.
  input wire logic [4:0] raddr, // Read index.
  output logic [15:0] rdata_q // Registered read data.
);
  logic [15:0] mem_q [DEPTH];

  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++)
    begin : g_word
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          mem_q[gi] <= 16'h0000;
        else if (wr.we && wr.addr == 5'(gi))
          mem_q[gi] <= wr.data;
      end
    end
  endgenerate

  // Registered read port; out-of-range indexes read zero.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rdata_q <= 16'h0000;
    else
      rdata_q <= (int'(raddr) < DEPTH) ? mem_q[raddr] : 16'h0000;
  end
endmodule // asc_result_mem
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking testbench for the A/D result storage controller.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic trig_a = 1'b0;
  logic trig_b = 1'b0;
  logic [11:0] analog_code = 12'h000;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q, sh_start_q, busy_q;
  logic [4:0] sh_chan_q;
  logic [31:0] rd;
  logic err;
  int n_errors = 0;
  int checks_done = 0;
  int cyc[2];
  int dif[5] = '{10, 5, 20, 40, 80};
  int tol[5] = '{1, 1, 2, 4, 8};
  logic [7:0] xaddr[5] = '{8'h4c, 8'h84, 8'h8c, 8'h90, 8'h94};

  // Bus clock of 8 ns period.
  always #4 pclk = ~pclk;

  asc_ctrl #(.NCH(18)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q),
    .pslverr_q(pslverr_q), .trig_a(trig_a), .trig_b(trig_b), .analog_code(analog_code),
    .sh_start_q(sh_start_q), .sh_chan_q(sh_chan_q), .busy_q(busy_q));

  // Prints the counts and the verdict, then stops the run.
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Compares one value and counts the result.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Compares a measured cycle count against a window.
  task automatic chk_near(input int got, input int exp, input int tl);
    checks_done++;
    if (got > exp + tl || got < exp - tl)
    begin
      n_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready_q !== 1'b1 && n < 40);
    if (n >= 40)
      chk(32'h1, 32'h0);
    rd = prdata_q;
    err = pslverr_q;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Reads one word and compares it.
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    chk(rd, exp);
  endtask

  // Drives a one-cycle trigger pulse, A when sel is low, B otherwise.
  task automatic pulse(input logic sel);
    @(posedge pclk);
    if (sel)
      trig_b <= 1'b1;
    else
      trig_a <= 1'b1;
    @(posedge pclk);
    trig_a <= 1'b0;
    trig_b <= 1'b0;
  endtask

  // Waits a bounded time for the next conversion start pulse.
  task automatic wait_start;
    int n;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (sh_start_q !== 1'b1 && n < 2000);
    if (n >= 2000)
      chk(32'h1, 32'h0);
  endtask

  // Starts a scan by command or trigger and counts cycles until it ends.
  task automatic run(input logic by_trig, output int c);
    if (by_trig)
      pulse(1'b0);
    else
      apb(8'h04, 1'b1, 32'h1);
    c = 0;
    do
    begin
      @(posedge pclk);
      c++;
    end
    while (busy_q !== 1'b0 && c < 5000);
    if (c >= 5000)
      chk(32'h1, 32'h0);
  endtask

  // Watchdog reckoned well above the expected length of all tests.
  initial
  begin
    repeat (60000) @(posedge pclk);
    n_errors++;
    end_sim();
  end

  // Main sequence of tests.
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(busy_q, 1'b0);
    rdchk(8'h08, 32'h0);
    apb(8'h98, 1'b0, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    $display("test reset_and_map done");
    // Each ratio and cycle bit: result stored, time difference scales with the ratio.
    for (int r = 0; r < 5; r++)
    begin
      for (int f = 0; f < 2; f++)
      begin
        apb(8'h00, 1'b1, (32'(r) << 7) | (32'(f) << 2));
        apb(8'h0c, 1'b1, 32'h1);
        analog_code <= 12'h100 + 12'(r * 2 + f);
        run(1'b0, cyc[f]);
        rdchk(8'h40, 32'h100 + 32'(r * 2 + f));
      end
      chk_near(cyc[0] - cyc[1], dif[r], tol[r]);
    end
    $display("test ratio_timing done");
    apb(8'h00, 1'b1, 32'h0003_8000);
    apb(8'h0c, 1'b1, 32'h0002_0008);
    analog_code <= 12'habc;
    run(1'b1, cyc[0]);
    for (int i = 0; i < 5; i++)
      rdchk(xaddr[i], 32'habc);
    rdchk(8'h50, 32'h0);
    apb(8'h4c, 1'b1, 32'hffff);
    rdchk(8'h4c, 32'habc);
    pulse(1'b1);
    repeat (30) @(posedge pclk);
    chk(busy_q, 1'b0);
    $display("test single_extras done");
    analog_code <= 12'hfff;
    apb(8'h0c, 1'b1, 32'h40);
    apb(8'h00, 1'b1, 32'h10);
    run(1'b0, cyc[0]);
    rdchk(8'h58, 32'h3ffc);
    apb(8'h00, 1'b1, 32'h30);
    run(1'b0, cyc[0]);
    rdchk(8'h58, 32'hfff0);
    $display("test addition done");
    apb(8'h00, 1'b1, 32'h1c08);
    apb(8'h0c, 1'b1, 32'h80);
    analog_code <= 12'h111;
    run(1'b0, cyc[0]);
    analog_code <= 12'h222;
    run(1'b1, cyc[0]);
    rdchk(8'h5c, 32'h111);
    rdchk(8'h88, 32'h222);
    $display("test double_trigger done");
    apb(8'h00, 1'b1, 32'h1c09);
    apb(8'h0c, 1'b1, 32'h200);
    analog_code <= 12'h3a5;
    apb(8'h04, 1'b1, 32'h1);
    repeat (3) wait_start();
    chk(busy_q, 1'b1);
    apb(8'h04, 1'b1, 32'h4);
    repeat (200) @(posedge pclk);
    chk(busy_q, 1'b0);
    rdchk(8'h64, 32'h3a5);
    rdchk(8'h88, 32'h222);
    $display("test continuous done");
    apb(8'h00, 1'b1, 32'h42);
    apb(8'h0c, 1'b1, 32'h2);
    apb(8'h10, 1'b1, 32'h3fc00);
    analog_code <= 12'h5a5;
    pulse(1'b1);
    wait_start();
    pulse(1'b0);
    wait_start();
    chk(sh_chan_q, 5'h01);
    run(1'b0, cyc[0]);
    rdchk(8'h44, 32'h5a5);
    rdchk(8'h68, 32'h0);
    $display("test group_priority done");
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
